//--- core/internal_bus_signal_router.sv
// Internal bus signal router: three shared lines, output and input selectors,
// APB register file with interrupt.
// Assumes pins arrive asynchronous; channel status and stop flag on pclk.
//
// Operation
// [R01] Three shared lines, three output and three input selectors per unit.
// [R02] Input functions only with high-function unit and not over distributed link.
// [R03] Lines one and two appear at the end unit's auxiliary outputs.
// [R04] A driving unit reads its own line back as input.
// [R05] Event inputs and auxiliary outputs are linkable through the lines.
// [R06] Input selector: disabled, bank bits, run/stop both senses, auto/manual, setpoint.
// [R07] Channels three and four exist only on the four-channel variant.
// [R08] All-channel output sources: errors, alarm ORs/ANDs, events, bus inputs.
// [R09] Per-channel output sources: alarms, errors, heater alarms, bank, modes.
// [R10] Controller error is the OR of status word A bits 0 to 13.
// [R11] Input selector code range 0-132 or 0-69, default 0.
// [R12] Output selector code range 0-150 or 0-87, default 0.
// [R13] Selectors written only while stopped; applied at soft reset or power-on.
// [R14] Configuring party disables all selectors before writing new codes.
// [R15] Configuring party keeps selectors consistent across all units.
// [R16] Bank number from bank bit 1 high and bit 0 low.
// [R17] Bank change on a line switches all linked units together.
// [R18] Level input functions follow the present line level.
`timescale 1ns/100ps
`default_nettype none
`include "bus_router_map.svh"

module internal_bus_signal_router
    import bus_router_pkg::*;
#(
    parameter int NUM_CH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [`NUM_LINES-1:0] line_in,
    output logic [`NUM_LINES-1:0] line_out,
    output logic [`NUM_LINES-1:0] line_oe_n,
    output logic aux_output_first,
    output logic aux_output_second,
    input wire logic high_function_unit_present,
    input wire logic distributed_link,
    input wire logic op_stopped,
    input wire logic [3:0] event_in,
    input wire logic [15:0] dev_status_a,
    input wire chan_stat_t [`MAX_CH-1:0] chan_stat,
    output chan_ctl_t [`MAX_CH-1:0] chan_ctl,
    output logic irq
);

    // ------------------------------------------------------------
    // Limits and helpers
    // ------------------------------------------------------------
    localparam logic [`SEL_W-1:0] IN_MAX = (NUM_CH > 2) ? `IN_MAX_4CH : `IN_MAX_2CH; // R11
    localparam logic [`SEL_W-1:0] OUT_MAX = (NUM_CH > 2) ? `OUT_MAX_4CH : `OUT_MAX_2CH; // R12

    // Split a selector code into all-channel or channel plus function
    function automatic sel_dec_t decode_sel(input logic [`SEL_W-1:0] code,
                                            input logic [`SEL_W-1:0] base,
                                            input logic [`SEL_W-1:0] all_max,
                                            input logic [`SEL_W-1:0] fn_max);
        sel_dec_t d;
        logic [`SEL_W-1:0] off;
        d = '0;
        off = code - base;
        if (code != '0 && code <= all_max) begin
            d.all = 1'b1;
            d.fn = code[`FN_W-1:0];
        end else if (code > base && int'(off[`SEL_W-1:`FN_W]) < NUM_CH
                     && off[`FN_W-1:0] != '0 && off[`FN_W-1:0] <= fn_max[`FN_W-1:0]) begin
            d.ch = off[`FN_W+1:`FN_W]; // R07
            d.fn = off[`FN_W-1:0];
        end
        return d;
    endfunction : decode_sel

    // Per-channel output source vector
    function automatic logic [`SRC_W-1:0] chan_src(input chan_stat_t s);
        logic [`SRC_W-1:0] v;
        v = '0;
        v[`PS_ALM +: 3] = s.alarm;
        v[`PS_ALL_OR] = |s.alarm;
        v[`PS_ALL_AND] = &s.alarm;
        v[`PS_INERR] = s.in_err;
        v[`PS_REMERR] = s.remote_err;
        v[`PS_HTR_BRK] = s.heater_break_alarm;
        v[`PS_HTR_SHORT] = s.heater_short_alarm;
        v[`PS_HTR_OVER] = s.heater_overcurrent_alarm;
        v[`PS_BANK +: 2] = s.bank;
        v[`PS_RUN] = s.running;
        v[`PS_MAN] = s.manual;
        v[`PS_REM] = s.remote_setpoint;
        return v;
    endfunction : chan_src

    // Hit and word index in a bank of three selector words
    function automatic logic [2:0] bank_hit(input logic [`ADDR_W-1:0] a,
                                            input logic [`ADDR_W-1:0] base);
        logic [`ADDR_W-1:0] off;
        off = a - base;
        return {(a >= base) && (off < `SEL_SPAN) && (a[1:0] == 2'h0), off[3:2]};
    endfunction : bank_hit

    // ------------------------------------------------------------
    // Output source evaluation
    // ------------------------------------------------------------
    logic [`MAX_CH-1:0][`SRC_W-1:0] ch_src;
    logic [`SRC_W-1:0] ps_or;
    logic [`SRC_W-1:0] ps_and;
    logic [`SRC_W-1:0] all_src;
    state_t s_r;
    state_t s_nxt;

    // Channel sources and their OR/AND over present channels
    always_comb begin
        ps_or = '0;
        ps_and = '1;
        all_src = '0;
        for (int c = 0; c < `MAX_CH; c++) begin
            ch_src[c] = chan_src(chan_stat[c]); // R09
            if (c < NUM_CH) begin
                ps_or = ps_or | ch_src[c];
                ps_and = ps_and & ch_src[c];
            end
        end
        all_src[`SRC_CTRL_ERR] = |dev_status_a[`STS_ERR_HI:0]; // R10
        all_src[`SRC_ALL_OR] = ps_or[`PS_ALL_OR]; // R08
        all_src[`SRC_ALL_AND] = ps_and[`PS_ALL_AND];
        for (int k = 0; k < 3; k++) begin
            all_src[`SRC_ALM_OR + k] = ps_or[`PS_ALM + k];
            all_src[`SRC_ALM_AND + k] = ps_and[`PS_ALM + k];
            all_src[`SRC_LINE + k] = s_r.ln_s2[k]; // R04
        end
        all_src[`SRC_INERR_OR] = ps_or[`PS_INERR];
        all_src[`SRC_REMERR_OR] = ps_or[`PS_REMERR];
        all_src[`SRC_BRK_OR] = ps_or[`PS_HTR_BRK];
        all_src[`SRC_SHORT_OR] = ps_or[`PS_HTR_SHORT];
        all_src[`SRC_OVER_OR] = ps_or[`PS_HTR_OVER];
        for (int k = 0; k < 4; k++) begin
            all_src[`SRC_EVENT + k] = s_r.ev_s2[k]; // R05
        end
    end

    // ------------------------------------------------------------
    // Next state: sync, routing, registers
    // ------------------------------------------------------------
    logic setup;
    logic access;
    logic avail;
    logic [2:0] h_in;
    logic [2:0] h_out;
    logic [2:0] h_in_act;
    logic [2:0] h_out_act;
    logic [`SEL_W-1:0] wcode;

    assign setup = psel & ~penable;
    assign access = psel & penable;
    assign avail = s_r.pin_s2[`PIN_HF_UNIT] & ~s_r.pin_s2[`PIN_DIST]; // R02
    assign h_in = bank_hit(paddr, `OFS_IN_SEL);
    assign h_out = bank_hit(paddr, `OFS_OUT_SEL);
    assign h_in_act = bank_hit(paddr, `OFS_IN_ACT);
    assign h_out_act = bank_hit(paddr, `OFS_OUT_ACT);
    assign wcode = pwdata[`SEL_W-1:0];

    always_comb begin
        sel_dec_t d;
        logic [31:0] rd;
        logic [`IRQ_W-1:0] set;
        logic [`IRQ_W-1:0] clr;
        logic bad;
        d = '0;
        rd = '0;
        set = '0;
        clr = '0;
        bad = 1'b0;
        s_nxt = s_r;

        // Two-stage synchronisers for pins and shared lines
        s_nxt.ln_s1 = line_in;
        s_nxt.ln_s2 = s_r.ln_s1;
        s_nxt.ln_prev = s_r.ln_s2;
        s_nxt.ev_s1 = event_in;
        s_nxt.ev_s2 = s_r.ev_s1;
        s_nxt.pin_s1 = {distributed_link, high_function_unit_present};
        s_nxt.pin_s2 = s_r.pin_s1;
        set[`IRQ_LINE +: `NUM_LINES] = s_r.ln_s2 ^ s_r.ln_prev;

        // Drive each line from its active output selector
        for (int i = 0; i < `NUM_LINES; i++) begin
            d = decode_sel(s_r.out_act[i], `OUT_CH_BASE, `SRC_ALL_MAX, `PS_MAX); // R01
            s_nxt.drv_en[i] = (d.fn != '0);
            s_nxt.drv[i] = d.all ? all_src[d.fn] : ch_src[d.ch][d.fn];
        end

        // Input functions follow present line levels, on all channels or on the one channel coded
        s_nxt.ctl = '0;
        for (int i = 0; i < `NUM_LINES; i++) begin
            d = decode_sel(s_r.in_act[i], `IN_CH_BASE, `FN_MAX, `FN_MAX); // R06
            for (int c = 0; c < NUM_CH; c++) begin
                if (avail && d.fn != '0 && (d.all || int'(d.ch) == c)) begin // R02
                    unique case (int'(d.fn))
                        `FN_BANK, `FN_BANK + 1: begin
                            s_nxt.ctl[c].bank_en[d.fn == `FN_BANK + 1] = 1'b1; // R17
                            s_nxt.ctl[c].bank[d.fn == `FN_BANK + 1] = s_r.ln_s2[i]; // R16
                        end
                        `FN_RUN: begin
                            s_nxt.ctl[c].run_en = 1'b1;
                            s_nxt.ctl[c].run = s_r.ln_s2[i]; // R18
                        end
                        `FN_STOP: begin
                            s_nxt.ctl[c].run_en = 1'b1;
                            s_nxt.ctl[c].run = ~s_r.ln_s2[i];
                        end
                        `FN_MAN: begin
                            s_nxt.ctl[c].man_en = 1'b1;
                            s_nxt.ctl[c].man = s_r.ln_s2[i];
                        end
                        `FN_REM: begin
                            s_nxt.ctl[c].rem_en = 1'b1;
                            s_nxt.ctl[c].rem = s_r.ln_s2[i];
                        end
                        default: begin
                        end
                    endcase
                end
            end
        end

        // Setup phase: read data and error for this access
        if (h_in[2]) begin
            rd[`SEL_W-1:0] = s_r.in_pend[h_in[1:0]];
            bad = pwrite && (!op_stopped || wcode > IN_MAX); // R11
        end else if (h_out[2]) begin
            rd[`SEL_W-1:0] = s_r.out_pend[h_out[1:0]];
            bad = pwrite && (!op_stopped || wcode > OUT_MAX); // R12
        end else if (h_in_act[2]) begin
            rd[`SEL_W-1:0] = s_r.in_act[h_in_act[1:0]];
        end else if (h_out_act[2]) begin
            rd[`SEL_W-1:0] = s_r.out_act[h_out_act[1:0]];
        end else if (paddr == `OFS_STAT) begin
            rd[`STAT_LINES +: `NUM_LINES] = s_r.ln_s2;
            rd[`STAT_AVAIL] = avail;
            rd[`STAT_HF_UNIT] = s_r.pin_s2[`PIN_HF_UNIT];
            rd[`STAT_DIST] = s_r.pin_s2[`PIN_DIST];
            rd[`STAT_STOPPED] = op_stopped;
            rd[`STAT_PENDING] = (s_r.in_pend != s_r.in_act) || (s_r.out_pend != s_r.out_act);
        end else if (paddr == `OFS_IRQ_STAT) begin
            rd[`IRQ_W-1:0] = s_r.irq_stat;
        end else if (paddr == `OFS_IRQ_MASK) begin
            rd[`IRQ_W-1:0] = s_r.irq_mask;
        end else if (paddr != `OFS_CTRL) begin
            bad = 1'b1;
        end
        if (setup) begin
            s_nxt.rdata = pwrite ? '0 : rd;
            s_nxt.err = bad;
        end

        // Access phase: writes take effect
        if (access && pwrite && !s_r.err) begin
            if (h_in[2]) begin
                s_nxt.in_pend[h_in[1:0]] = wcode; // R13
            end else if (h_out[2]) begin
                s_nxt.out_pend[h_out[1:0]] = wcode; // R13
            end else if (paddr == `OFS_IRQ_STAT) begin
                clr = pwdata[`IRQ_W-1:0];
            end else if (paddr == `OFS_IRQ_MASK) begin
                s_nxt.irq_mask = pwdata[`IRQ_W-1:0];
            end else if (paddr == `OFS_CTRL && pwdata[`CTRL_SOFT_RST]) begin
                s_nxt.in_act = s_r.in_pend; // R13
                s_nxt.out_act = s_r.out_pend;
                set[`IRQ_APPLIED] = 1'b1;
            end
        end
        if (access && pwrite && s_r.err && (h_in[2] || h_out[2])) begin
            set[`IRQ_REJECT] = 1'b1;
        end

        // Sticky status, set wins over clear
        s_nxt.irq_stat = (s_r.irq_stat & ~clr) | set;
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    // Power-on clears all selectors to disabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r <= '0; // R11 R12
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Bus answer, zero wait states
    assign pready = 1'b1;
    assign prdata = s_r.rdata;
    assign pslverr = access & s_r.err;

    // Shared lines and end unit auxiliary outputs
    assign line_out = s_r.drv;
    assign line_oe_n = ~s_r.drv_en;
    assign aux_output_first = s_r.ln_s2[0]; // R03
    assign aux_output_second = s_r.ln_s2[1]; // R03

    // Control to the channels and interrupt
    assign chan_ctl = s_r.ctl;
    assign irq = |(s_r.irq_stat & s_r.irq_mask);

endmodule : internal_bus_signal_router

`default_nettype wire

//--- core/bus_router_map.svh
// Register map, field positions and selector code layout of the bus router.
// Safe to include from any file.
`ifndef BUS_ROUTER_MAP_SVH
`define BUS_ROUTER_MAP_SVH

// Sizes
`define MAX_CH 4
`define NUM_LINES 3
`define SEL_W 8
`define FN_W 5
`define SRC_W 32
`define IRQ_W 5
`define ADDR_W 12

// Register offsets (byte addresses)
`define OFS_CTRL 12'h000
`define OFS_STAT 12'h004
`define OFS_IRQ_STAT 12'h008
`define OFS_IRQ_MASK 12'h00C
`define OFS_IN_SEL 12'h010
`define OFS_OUT_SEL 12'h01C
`define OFS_IN_ACT 12'h028
`define OFS_OUT_ACT 12'h034
`define SEL_SPAN 12'h00C

// Control, status and interrupt fields
`define CTRL_SOFT_RST 0
`define STAT_LINES 0
`define STAT_AVAIL 3
`define STAT_HF_UNIT 4
`define STAT_DIST 5
`define STAT_STOPPED 6
`define STAT_PENDING 7
`define IRQ_LINE 0
`define IRQ_REJECT 3
`define IRQ_APPLIED 4
`define PIN_HF_UNIT 0
`define PIN_DIST 1

// Selector code limits and per-channel block bases (channel stride 2**FN_W)
`define IN_MAX_4CH 8'h84
`define IN_MAX_2CH 8'h45
`define OUT_MAX_4CH 8'h96
`define OUT_MAX_2CH 8'h57
`define IN_CH_BASE 8'h10
`define OUT_CH_BASE 8'h20
`define STS_ERR_HI 13

// Input functions
`define FN_BANK 1
`define FN_RUN 3
`define FN_STOP 4
`define FN_MAN 5
`define FN_REM 6
`define FN_MAX 8'h06

// All-channel output sources
`define SRC_CTRL_ERR 1
`define SRC_ALL_OR 2
`define SRC_ALL_AND 3
`define SRC_ALM_OR 4
`define SRC_ALM_AND 7
`define SRC_INERR_OR 10
`define SRC_REMERR_OR 11
`define SRC_BRK_OR 12
`define SRC_SHORT_OR 13
`define SRC_OVER_OR 14
`define SRC_EVENT 15
`define SRC_LINE 19
`define SRC_ALL_MAX 8'h15

// Per-channel output sources
`define PS_ALM 1
`define PS_ALL_OR 4
`define PS_ALL_AND 5
`define PS_INERR 6
`define PS_REMERR 7
`define PS_HTR_BRK 8
`define PS_HTR_SHORT 9
`define PS_HTR_OVER 10
`define PS_BANK 11
`define PS_RUN 13
`define PS_MAN 14
`define PS_REM 15
`define PS_MAX 8'h0F

`endif

//--- core/bus_router_pkg.sv
// Types of the internal bus signal router.
// Assumes the map header sits beside it on the include path.
package bus_router_pkg;
`include "bus_router_map.svh"

    // Per-channel state offered by the controller core
    typedef struct packed {
        logic [2:0] alarm;
        logic in_err;
        logic remote_err;
        logic heater_break_alarm;
        logic heater_short_alarm;
        logic heater_overcurrent_alarm;
        logic [1:0] bank;
        logic running;
        logic manual;
        logic remote_setpoint;
    } chan_stat_t;

    // Per-channel control taken from the shared lines
    typedef struct packed {
        logic [1:0] bank_en;
        logic [1:0] bank;
        logic run_en;
        logic run;
        logic man_en;
        logic man;
        logic rem_en;
        logic rem;
    } chan_ctl_t;

    // Decoded selector code
    typedef struct packed {
        logic all;
        logic [1:0] ch;
        logic [`FN_W-1:0] fn;
    } sel_dec_t;

    // Whole state of the router
    typedef struct packed {
        logic [`NUM_LINES-1:0] ln_s1;
        logic [`NUM_LINES-1:0] ln_s2;
        logic [`NUM_LINES-1:0] ln_prev;
        logic [3:0] ev_s1;
        logic [3:0] ev_s2;
        logic [1:0] pin_s1;
        logic [1:0] pin_s2;
        logic [`NUM_LINES-1:0][`SEL_W-1:0] in_pend;
        logic [`NUM_LINES-1:0][`SEL_W-1:0] out_pend;
        logic [`NUM_LINES-1:0][`SEL_W-1:0] in_act;
        logic [`NUM_LINES-1:0][`SEL_W-1:0] out_act;
        logic [`IRQ_W-1:0] irq_stat;
        logic [`IRQ_W-1:0] irq_mask;
        logic [31:0] rdata;
        logic err;
        logic [`NUM_LINES-1:0] drv;
        logic [`NUM_LINES-1:0] drv_en;
        chan_ctl_t [`MAX_CH-1:0] ctl;
    } state_t;

endpackage : bus_router_pkg

//--- verif/bus_router_asserts.sv
// Port-level assertions of the internal bus signal router.
// Assumes binding to internal_bus_signal_router and one clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "bus_router_map.svh"

module bus_router_asserts
    import bus_router_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [`NUM_LINES-1:0] line_in,
    input wire logic [`NUM_LINES-1:0] line_oe_n,
    input wire logic aux_output_first,
    input wire logic aux_output_second,
    input wire logic high_function_unit_present,
    input wire logic distributed_link,
    input wire chan_ctl_t [`MAX_CH-1:0] chan_ctl,
    input wire logic irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // ----
    // Helpers
    // ----
    logic [2:0] up_cnt;
    logic [2:0] off_cnt;
    logic apply_hit;

    // Soft reset write in its access cycle
    assign apply_hit = psel && penable && pwrite && paddr == `OFS_CTRL && pwdata[0];

    // Cycles since reset and cycles with bus inputs barred, both saturating
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_cnt <= 3'h0;
            off_cnt <= 3'h0;
        end else begin
            up_cnt <= (up_cnt == 3'h7) ? up_cnt : up_cnt + 3'h1;
            if (high_function_unit_present && !distributed_link)
                off_cnt <= 3'h0;
            else if (off_cnt != 3'h7)
                off_cnt <= off_cnt + 3'h1;
        end
    end

    // ----
    // Assertions
    // ----
    chk_pready_high:
        assert property (pready)
        else $error("pready low");
    chk_slverr_access:
        assert property (pslverr |-> psel && penable)
        else $error("slave error outside access");
    chk_write_rdata:
        assert property (psel && penable && pwrite |-> prdata == 32'h0)
        else $error("read data during write");
    chk_irq_clear:
        assert property ($fell(irq) |-> $past(psel && penable && pwrite
            && (paddr == `OFS_IRQ_STAT || paddr == `OFS_IRQ_MASK)))
        else $error("interrupt dropped without a write");
    chk_oe_apply:
        assert property ($changed(line_oe_n) |-> $past(apply_hit, 2) || $past(apply_hit, 3))
        else $error("drive enables changed without apply");
    chk_ctl_barred:
        assert property (off_cnt >= 3'h4 |-> chan_ctl == '0)
        else $error("bus input function active while barred");
    chk_aux_first:
        assert property ((up_cnt == 3'h7 && $stable(line_in[0])) [*4]
            |-> aux_output_first == line_in[0])
        else $error("first aux output differs from line one");
    chk_aux_second:
        assert property ((up_cnt == 3'h7 && $stable(line_in[1])) [*4]
            |-> aux_output_second == line_in[1])
        else $error("second aux output differs from line two");

    // ----
    // Covers
    // ----
    cover property (pslverr);
    cover property ($fell(irq));
    cover property ($changed(line_oe_n));
endmodule : bus_router_asserts

bind internal_bus_signal_router bus_router_asserts bus_router_asserts_inst (.*);
`default_nettype wire

//--- verif/other_units.sv
// Model of the other units sharing the three lines.
// Assumes wired-OR lines with pull-downs; peers drive what the bench asks.
`timescale 1ns/100ps
`default_nettype none
`include "bus_router_map.svh"

module other_units (
    input wire logic [`NUM_LINES-1:0] line_out,
    input wire logic [`NUM_LINES-1:0] line_oe_n,
    input wire logic [`NUM_LINES-1:0] peer_drive,
    output logic [`NUM_LINES-1:0] line_in
);
    // Resolved level; a released line falls to the pull-down
    assign line_in = (line_out & ~line_oe_n) | peer_drive;
endmodule : other_units
`default_nettype wire

//--- verif/test_internal_bus_signal_router.sv
// Self-checking bench of the internal bus signal router.
// Assumes the package, the map header, the peer model and the checker.
`timescale 1ns/100ps
`default_nettype none
`include "bus_router_map.svh"

module test_internal_bus_signal_router
    import bus_router_pkg::*;
;

    // ----
    // Signals
    // ----
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err_seen;
    logic [`ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [`NUM_LINES-1:0] line_in, line_out, line_oe_n, peer_drive;
    logic aux_output_first, aux_output_second;
    logic high_function_unit_present, distributed_link, op_stopped;
    logic [3:0] event_in;
    logic [15:0] dev_status_a;
    chan_stat_t [`MAX_CH-1:0] chan_stat;
    chan_ctl_t [`MAX_CH-1:0] chan_ctl;
    int errors = 0;
    int num_checks = 0;
    localparam logic [9:0] FN_EXP [6] = '{10'h140, 10'h280, 10'h030, 10'h020, 10'h00C, 10'h003};

    internal_bus_signal_router #(.NUM_CH(4)) internal_bus_signal_router_inst (.*);
    other_units other_units_inst (.line_out(line_out), .line_oe_n(line_oe_n),
        .peer_drive(peer_drive), .line_in(line_in));

    // Clock and watchdog
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    initial begin
        #150000;
        errors++;
        give_verdict();
    end

    // ----
    // Tasks
    // ----
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic apb(input logic wr, input logic [`ADDR_W-1:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [`ADDR_W-1:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0);
        check(what, exp, rd);
    endtask : rd_chk

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : tick

    task automatic apply;
        apb(1'b1, `OFS_CTRL, 32'h1);
    endtask : apply

    // ----
    // Sequence
    // ----
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        peer_drive = '0;
        high_function_unit_present = 1'b0;
        distributed_link = 1'b0;
        op_stopped = 1'b0;
        event_in = '0;
        dev_status_a = '0;
        chan_stat = '0;
        presetn = 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk(`OFS_STAT, 32'h0, "status");
        rd_chk(`OFS_IN_SEL, 32'h0, "in sel");
        rd_chk(`OFS_OUT_SEL + 12'h008, 32'h0, "out sel");
        rd_chk(12'hFFC, 32'h0, "unmapped");
        check("slverr", 32'h1, {31'h0, err_seen});
        $display("done: reset values");
        apb(1'b1, `OFS_IN_SEL, 32'h1);
        rd_chk(`OFS_IN_SEL, 32'h0, "sel while running");
        rd_chk(`OFS_IRQ_STAT, 32'h08, "reject flag");
        apb(1'b1, `OFS_IRQ_MASK, 32'h1F);
        tick(1);
        check("irq set", 32'h1, {31'h0, irq});
        apb(1'b1, `OFS_IRQ_STAT, 32'h1F);
        tick(1);
        check("irq clear", 32'h0, {31'h0, irq});
        $display("done: refused write");
        @(posedge pclk) op_stopped <= 1'b1;
        for (int k = 0; k < 6; k++) apb(1'b1, `OFS_IN_SEL + 12'(4 * k), 32'h0);
        apb(1'b1, `OFS_IN_SEL, 32'h85);
        rd_chk(`OFS_IN_SEL, 32'h0, "in sel 133");
        apb(1'b1, `OFS_IN_SEL, 32'h84);
        rd_chk(`OFS_IN_SEL, 32'h84, "in sel 132");
        apb(1'b1, `OFS_OUT_SEL, 32'h97);
        rd_chk(`OFS_OUT_SEL, 32'h0, "out sel 151");
        apb(1'b1, `OFS_OUT_SEL, 32'h96);
        rd_chk(`OFS_OUT_SEL, 32'h96, "out sel 150");
        rd_chk(`OFS_STAT, 32'hC0, "pending");
        for (int k = 0; k < 6; k++) apb(1'b1, `OFS_IN_SEL + 12'(4 * k), 32'h0);
        $display("done: code limits");
        @(posedge pclk) high_function_unit_present <= 1'b1;
        dev_status_a <= 16'h2000;
        apb(1'b1, `OFS_OUT_SEL, 32'h1);
        tick(8);
        check("oe before apply", 32'h7, {29'h0, line_oe_n});
        apply();
        tick(8);
        check("oe", 32'h6, {29'h0, line_oe_n});
        check("ctrl err bit13", 32'h1, {31'h0, line_out[0]});
        check("aux first", 32'h1, {31'h0, aux_output_first});
        rd_chk(`OFS_OUT_ACT, 32'h1, "active");
        @(posedge pclk) dev_status_a <= 16'hC000;
        tick(8);
        check("ctrl err bit14", 32'h0, {31'h0, line_out[0]});
        @(posedge pclk) dev_status_a <= 16'h0001;
        tick(8);
        check("ctrl err bit0", 32'h1, {31'h0, line_out[0]});
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, `OFS_OUT_SEL + 12'h004, 32'(`SRC_EVENT + i));
            apply();
            @(posedge pclk) event_in <= 4'h1 << i;
            tick(8);
            check("event line", 32'h1, {31'h0, line_out[1]});
            check("aux second", 32'h1, {31'h0, aux_output_second});
            @(posedge pclk) event_in <= ~(4'h1 << i);
            tick(8);
            check("other events", 32'h0, {31'h0, line_out[1]});
        end
        @(posedge pclk) event_in <= '0;
        apb(1'b1, `OFS_OUT_SEL + 12'h008, 32'h21);
        apply();
        @(posedge pclk) chan_stat[0].alarm <= 3'b001;
        tick(8);
        check("channel alarm", 32'h1, {31'h0, line_out[2]});
        @(posedge pclk) chan_stat[0].alarm <= 3'b010;
        tick(8);
        check("other alarm", 32'h0, {31'h0, line_out[2]});
        $display("done: output sources");
        for (int f = 1; f <= 6; f++) begin
            for (int k = 0; k < 2; k++) begin
                apb(1'b1, `OFS_IN_SEL, k ? 32'(8'h70 + f) : 32'(f));
                apply();
                tick(8);
                check("ctl ch4", {22'h0, FN_EXP[f - 1]}, {22'h0, chan_ctl[3]});
                check("ctl ch1", k ? 32'h0 : {22'h0, FN_EXP[f - 1]}, {22'h0, chan_ctl[0]});
            end
        end
        $display("done: input functions");
        apb(1'b1, `OFS_IN_SEL, 32'h1);
        apb(1'b1, `OFS_IN_SEL + 12'h004, 32'h2);
        apb(1'b1, `OFS_OUT_SEL, 32'h0);
        apb(1'b1, `OFS_OUT_SEL + 12'h004, 32'h0);
        apply();
        for (int p = 0; p < 4; p++) begin
            @(posedge pclk) peer_drive <= 3'(p);
            tick(8);
            for (int c = 0; c < 4; c++)
                check("bank", {22'h0, 10'h300 | 10'(p * 64)}, {22'h0, chan_ctl[c]});
        end
        $display("done: bank select");
        @(posedge pclk) distributed_link <= 1'b1;
        tick(8);
        check("distributed", 32'h0, {22'h0, chan_ctl[0]});
        rd_chk(`OFS_STAT, 32'h73, "status distributed");
        @(posedge pclk) distributed_link <= 1'b0;
        high_function_unit_present <= 1'b0;
        tick(8);
        check("no hf unit", 32'h0, {22'h0, chan_ctl[3]});
        $display("done: input gating");
        @(posedge pclk) presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        tick(1);
        check("oe after reset", 32'h7, {29'h0, line_oe_n});
        rd_chk(`OFS_IN_ACT, 32'h0, "active after reset");
        $display("done: second reset");
        give_verdict();
    end
endmodule : test_internal_bus_signal_router
`default_nettype wire
